// file: core/phc_pkg.sv
// package: register map, defaults, field positions and types of the packet settings group
// Summary of operation
// - With fixed-length format the seven-bit length field sets the payload byte count for transmit and receive.
// - With variable-length format the length field is the largest receive payload and is not used for transmit.
// - An eight-bit node address, reset to zero, is held and compared against received packets.
// - Format bit 7 clear (default) selects fixed length, set selects variable length.
// - Preamble size codes 00, 01, 10, 11 give one to four bytes, default 10 giving three.
// - Filter mode 00 (default) accepts all, 01 node only, 10 node or 0x00, 11 node, 0x00 or 0xff; others rejected.
// - A read-only bit shows the current packet's CRC result, 1 pass and 0 fail.
// - Auto-clear bit clear (default) flushes the FIFO on CRC failure; set keeps the FIFO.
// - In standby the host may write the FIFO when the direction bit is 0 (default) and read it when 1.
package phc_pkg;
  localparam logic [4:0] ADDR_CODING = 5'h1c;
  localparam logic [4:0] ADDR_NODE = 5'h1d;
  localparam logic [4:0] ADDR_FORMAT = 5'h1e;
  localparam logic [4:0] ADDR_FIFOCTL = 5'h1f;
  localparam logic [7:0] RST_CODING = 8'h00;
  localparam logic [7:0] RST_NODE = 8'h00;
  localparam logic [7:0] RST_FORMAT = 8'h48;
  localparam logic [7:0] RST_FIFOCTL = 8'h00;
  localparam int BIT_MANCH = 7;
  localparam int BIT_VARLEN = 7;
  localparam int BIT_PRE_HI = 6;
  localparam int BIT_PRE_LO = 5;
  localparam int BIT_WHITEN = 4;
  localparam int BIT_CRC_ON = 3;
  localparam int BIT_FILT_HI = 2;
  localparam int BIT_FILT_LO = 1;
  localparam int BIT_CRC_STAT = 0;
  localparam int BIT_AUTOCLR_OFF = 7;
  localparam int BIT_STBY_READ = 6;
  localparam logic [7:0] BCAST_ZERO = 8'h00;
  localparam logic [7:0] BCAST_ONES = 8'hff;
  localparam logic [1:0] FILT_OFF = 2'h0;
  localparam logic [1:0] FILT_NODE = 2'h1;
  localparam logic [1:0] FILT_NODE_ZERO = 2'h2;
  localparam int FIFO_DEPTH = 8;
  localparam int DATA_W = 8;

  typedef enum logic [1:0] {
    PHC_RX_IDLE = 2'b00,
    PHC_RX_ADDR = 2'b01,
    PHC_RX_DATA = 2'b10,
    PHC_RX_DROP = 2'b11
  } phc_rx_state_t;

  // settings handed to the modem datapath
  typedef struct packed {
    logic manchester_en;
    logic whitening_en;
    logic crc_en;
    logic var_len;
    logic [2:0] preamble_bytes;
    logic [6:0] tx_length;
  } phc_cfg_t;
endpackage : phc_pkg

// file: core/phc_fifo.sv
// file: parameterised flip-flop FIFO with valid/ready on both sides and a flush
module phc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic room_q; // registered not-full, so the ready output comes from a flop
  logic empty_q;
  logic push;
  logic pop;

  assign push = in_valid_i && room_q;
  assign pop = out_ready_i && !empty_q;
  assign in_ready_o = room_q;
  assign out_valid_o = !empty_q;
  assign out_data_o = mem_q[rd_q];

  // next occupancy
  always_comb begin
    cnt_d = cnt_q;
    if (flush_i) begin
      cnt_d = '0;
    end else if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // storage write
  always_ff @(posedge clk_sys_i) begin
    if (push && !flush_i) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // pointers, count and registered flags
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || flush_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      room_q <= 1'b1;
      empty_q <= 1'b1;
    end else begin
      if (push) wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      if (pop) rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_d;
      room_q <= (cnt_d != CNT_FULL);
      empty_q <= (cnt_d == '0);
    end
  end
endmodule : phc_fifo

// file: core/phc_top.sv
// file: packet settings registers, receive length/address filter and FIFO access control
module phc_top #(
  parameter int FIFO_DEPTH = phc_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [4:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  output logic [7:0] cfg_rdata_o,
  output phc_pkg::phc_cfg_t cfg_o,
  input wire logic standby_i,
  input wire logic rx_valid_i,
  input wire logic rx_start_i,
  input wire logic [7:0] rx_data_i,
  output logic rx_ready_o,
  input wire logic crc_done_i,
  input wire logic crc_ok_i,
  input wire logic fifo_wr_i,
  input wire logic [7:0] fifo_wdata_i,
  input wire logic fifo_rd_i,
  output logic [7:0] fifo_rdata_o,
  output logic fifo_rvalid_o,
  output logic fifo_empty_o,
  output logic pkt_drop_o
);
  logic [7:0] coding_q;
  logic [7:0] node_q;
  logic [7:0] format_q;
  logic [7:0] fifoctl_q;
  logic crc_stat_q;
  phc_pkg::phc_rx_state_t rx_q;
  logic [6:0] remain_q;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [7:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic flush;
  logic var_len;
  logic [6:0] len_field;
  logic [1:0] filt;
  logic host_wr_ok;
  logic host_rd_ok;
  logic rx_take;
  logic rx_push;

  // address acceptance under the selected filter mode
  function automatic logic addr_ok(input logic [1:0] mode, input logic [7:0] node, input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    case (mode)
      phc_pkg::FILT_OFF: ok = 1'b1;
      phc_pkg::FILT_NODE: ok = (a == node);
      phc_pkg::FILT_NODE_ZERO: ok = (a == node) || (a == phc_pkg::BCAST_ZERO);
      default: ok = (a == node) || (a == phc_pkg::BCAST_ZERO) || (a == phc_pkg::BCAST_ONES);
    endcase
    return ok;
  endfunction : addr_ok

  assign var_len = format_q[phc_pkg::BIT_VARLEN];
  assign len_field = coding_q[6:0];
  assign filt = format_q[phc_pkg::BIT_FILT_HI:phc_pkg::BIT_FILT_LO];
  // standby access direction; outside standby the host drains received data
  assign host_wr_ok = standby_i && !fifoctl_q[phc_pkg::BIT_STBY_READ];
  assign host_rd_ok = !standby_i || fifoctl_q[phc_pkg::BIT_STBY_READ];
  assign rx_take = rx_valid_i && rx_ready_o && !standby_i;
  assign rx_push = rx_take && !(rx_start_i && var_len) && (rx_start_i ? 1'b1 : rx_q != phc_pkg::PHC_RX_DROP)
                   && !(rx_start_i ? (len_field == '0) : 1'b0)
                   && (((rx_start_i || rx_q == phc_pkg::PHC_RX_ADDR) && filt != phc_pkg::FILT_OFF)
                       ? addr_ok(filt, node_q, rx_data_i) : 1'b1)
                   && (rx_start_i || rx_q != phc_pkg::PHC_RX_IDLE);
  assign fifo_in_valid = rx_push || (host_wr_ok && fifo_wr_i);
  assign fifo_in_data = rx_push ? rx_data_i : fifo_wdata_i;
  assign fifo_out_ready = fifo_rd_i && host_rd_ok;
  // flush on a failed check unless auto-clear is switched off
  assign flush = crc_done_i && format_q[phc_pkg::BIT_CRC_ON] && !crc_ok_i
                 && !fifoctl_q[phc_pkg::BIT_AUTOCLR_OFF];
  assign rx_ready_o = fifo_in_ready;

  phc_fifo #(
    .WIDTH(phc_pkg::DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .flush_i(flush),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_in_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  // settings register writes
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      coding_q <= phc_pkg::RST_CODING;
      node_q <= phc_pkg::RST_NODE;
      format_q <= phc_pkg::RST_FORMAT;
      fifoctl_q <= phc_pkg::RST_FIFOCTL;
    end else if (cfg_wr_i) begin
      case (cfg_addr_i)
        phc_pkg::ADDR_CODING: coding_q <= cfg_wdata_i;
        phc_pkg::ADDR_NODE: node_q <= cfg_wdata_i;
        phc_pkg::ADDR_FORMAT: format_q <= cfg_wdata_i;
        phc_pkg::ADDR_FIFOCTL: fifoctl_q <= cfg_wdata_i;
        default: ;
      endcase
    end
  end

  // read-only check result, follows each finished packet
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      crc_stat_q <= 1'b0;
    end else if (crc_done_i) begin
      crc_stat_q <= crc_ok_i || !format_q[phc_pkg::BIT_CRC_ON];
    end
  end

  // register read port, unmapped addresses read zero
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cfg_rdata_o <= '0;
    end else if (cfg_rd_i) begin
      case (cfg_addr_i)
        phc_pkg::ADDR_CODING: cfg_rdata_o <= coding_q;
        phc_pkg::ADDR_NODE: cfg_rdata_o <= node_q;
        phc_pkg::ADDR_FORMAT: cfg_rdata_o <= {format_q[7:1], crc_stat_q};
        phc_pkg::ADDR_FIFOCTL: cfg_rdata_o <= fifoctl_q;
        default: cfg_rdata_o <= '0;
      endcase
    end
  end

  // settings presented to the modem
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cfg_o <= '0;
    end else begin
      cfg_o.manchester_en <= coding_q[phc_pkg::BIT_MANCH];
      cfg_o.whitening_en <= format_q[phc_pkg::BIT_WHITEN];
      cfg_o.crc_en <= format_q[phc_pkg::BIT_CRC_ON];
      cfg_o.var_len <= var_len;
      cfg_o.preamble_bytes <= {1'b0, format_q[phc_pkg::BIT_PRE_HI:phc_pkg::BIT_PRE_LO]} + 3'h1;
      cfg_o.tx_length <= var_len ? 7'h00 : len_field;
    end
  end

  // receive packet walker: length, address filter, payload count
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || standby_i) begin
      rx_q <= phc_pkg::PHC_RX_IDLE;
      remain_q <= '0;
      pkt_drop_o <= 1'b0;
    end else begin
      pkt_drop_o <= 1'b0;
      if (rx_take && rx_start_i) begin
        if (var_len) begin
          if (rx_data_i[7:0] == 8'h00 || rx_data_i > {1'b0, len_field}) begin
            rx_q <= phc_pkg::PHC_RX_DROP;
            pkt_drop_o <= 1'b1;
          end else begin
            rx_q <= (filt != phc_pkg::FILT_OFF) ? phc_pkg::PHC_RX_ADDR : phc_pkg::PHC_RX_DATA;
            remain_q <= rx_data_i[6:0];
          end
        end else if (len_field == '0) begin
          rx_q <= phc_pkg::PHC_RX_DROP;
          pkt_drop_o <= 1'b1;
        end else if (filt != phc_pkg::FILT_OFF && !addr_ok(filt, node_q, rx_data_i)) begin
          // swallow the rest of the rejected packet, then go idle
          rx_q <= (len_field == 7'h01) ? phc_pkg::PHC_RX_IDLE : phc_pkg::PHC_RX_DROP;
          remain_q <= len_field - 7'h01;
          pkt_drop_o <= 1'b1;
        end else begin
          rx_q <= (len_field == 7'h01) ? phc_pkg::PHC_RX_IDLE : phc_pkg::PHC_RX_DATA;
          remain_q <= len_field - 7'h01;
        end
      end else if (rx_take) begin
        case (rx_q)
          phc_pkg::PHC_RX_ADDR: begin
            if (!addr_ok(filt, node_q, rx_data_i)) begin
              rx_q <= (remain_q == 7'h01) ? phc_pkg::PHC_RX_IDLE : phc_pkg::PHC_RX_DROP;
              remain_q <= remain_q - 7'h01;
              pkt_drop_o <= 1'b1;
            end else begin
              rx_q <= (remain_q == 7'h01) ? phc_pkg::PHC_RX_IDLE : phc_pkg::PHC_RX_DATA;
              remain_q <= remain_q - 7'h01;
            end
          end
          phc_pkg::PHC_RX_DATA, phc_pkg::PHC_RX_DROP: begin
            remain_q <= remain_q - 7'h01;
            if (remain_q == 7'h01) rx_q <= phc_pkg::PHC_RX_IDLE;
          end
          default: rx_q <= phc_pkg::PHC_RX_IDLE;
        endcase
      end
    end
  end

  // host read data and status
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      fifo_rdata_o <= '0;
      fifo_rvalid_o <= 1'b0;
      fifo_empty_o <= 1'b1;
    end else begin
      fifo_rvalid_o <= fifo_out_ready && fifo_out_valid;
      if (fifo_out_ready && fifo_out_valid) fifo_rdata_o <= fifo_out_data;
      fifo_empty_o <= !fifo_out_valid;
    end
  end
endmodule : phc_top

// file: bench/phc_checker.sv
// checker: port-level properties of the packet settings block
module phc_checker #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [4:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_rdata_o,
  input phc_pkg::phc_cfg_t cfg_o,
  input wire logic rx_valid_i,
  input wire logic crc_done_i,
  input wire logic crc_ok_i,
  input wire logic fifo_rd_i,
  input wire logic fifo_rvalid_o,
  input wire logic pkt_drop_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  logic [7:0] wd_q;
  logic [7:0] wd2_q;
  wire wr_cod = cfg_wr_i && cfg_addr_i == phc_pkg::ADDR_CODING;
  wire wr_fmt = cfg_wr_i && cfg_addr_i == phc_pkg::ADDR_FORMAT;
  // write data delayed to line up with the settings output, which lags two edges
  always_ff @(posedge clk_sys_i) begin
    wd_q <= cfg_wdata_i;
    wd2_q <= wd_q;
  end
  AST_PRE: assert property (wr_fmt |-> ##2 cfg_o.preamble_bytes == {1'b0, wd2_q[6:5]} + 3'h1)
    else $error("preamble size does not follow code");
  AST_FMT: assert property (wr_fmt |-> ##2 cfg_o.var_len == wd2_q[7])
    else $error("length format bit not applied");
  AST_LEN: assert property (wr_cod |-> ##2 cfg_o.tx_length == (cfg_o.var_len ? 7'h00 : wd2_q[6:0]))
    else $error("transmit length wrong");
  AST_MAN: assert property (wr_cod |-> ##2 cfg_o.manchester_en == wd2_q[7])
    else $error("manchester enable not applied");
  AST_WCRC: assert property (wr_fmt |-> ##2 cfg_o.whitening_en == wd2_q[4] && cfg_o.crc_en == wd2_q[3])
    else $error("whitening or crc enable not applied");
  AST_STAT: assert property (crc_done_i && cfg_o.crc_en ##2 cfg_rd_i && cfg_addr_i == phc_pkg::ADDR_FORMAT
    |=> cfg_rdata_o[0] == $past(crc_ok_i, 3)) else $error("crc status bit wrong");
  AST_POP: assert property (fifo_rvalid_o |-> $past(fifo_rd_i))
    else $error("fifo byte without read request");
  AST_DROP: assert property (pkt_drop_o |-> $past(rx_valid_i))
    else $error("drop pulse without received byte");
  // main scenarios
  cover property (crc_done_i && !crc_ok_i);
  cover property (pkt_drop_o);
  cover property (fifo_rvalid_o);
endmodule : phc_checker

bind phc_top phc_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.clk_sys_i, .reset_i, .cfg_addr_i, .cfg_wdata_i,
  .cfg_wr_i, .cfg_rd_i, .cfg_rdata_o, .cfg_o, .rx_valid_i, .crc_done_i, .crc_ok_i, .fifo_rd_i, .fifo_rvalid_o,
  .pkt_drop_o);

// file: bench/phc_host_model.sv
// host model: drives the byte-wide settings port
module phc_host_model (
  input wire logic clk_sys_i,
  output logic [4:0] cfg_addr_o,
  output logic [7:0] cfg_wdata_o,
  output logic cfg_wr_o,
  output logic cfg_rd_o,
  input wire logic [7:0] cfg_rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cfg_addr_o = 5'h00;
    cfg_wdata_o = 8'h00;
    cfg_wr_o = 1'b0;
    cfg_rd_o = 1'b0;
  end
  // one-cycle write strobe, data scrambled once released
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    cfg_addr_o = a;
    cfg_wdata_o = d;
    cfg_wr_o = 1'b1;
    @(negedge clk_sys_i);
    cfg_wr_o = 1'b0;
    cfg_wdata_o = ~d;
  endtask : wr
  // one-cycle read strobe, answer taken after the next edge
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    cfg_addr_o = a;
    cfg_rd_o = 1'b1;
    @(negedge clk_sys_i);
    cfg_rd_o = 1'b0;
    d = cfg_rdata_i;
  endtask : rd
endmodule : phc_host_model

// file: bench/tb_packet_handler_config.sv
// testbench: settings registers, receive filter and FIFO control
module tb_packet_handler_config;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic standby_i = 1'b0, rx_valid_i = 1'b0, rx_start_i = 1'b0, crc_done_i = 1'b0, crc_ok_i = 1'b0;
  logic fifo_wr_i = 1'b0, fifo_rd_i = 1'b0, drop_seen = 1'b0, acc;
  logic [7:0] rx_data_i = 8'h00, fifo_wdata_i = 8'h00, rd_v, cfg_wdata_i, cfg_rdata_o, fifo_rdata_o;
  logic [4:0] cfg_addr_i;
  logic cfg_wr_i, cfg_rd_i, rx_ready_o, fifo_rvalid_o, fifo_empty_o, pkt_drop_o;
  phc_pkg::phc_cfg_t cfg_o;
  int miscompares = 0, num_checks = 0, cycles = 0;
  logic [4:0] ra [5] = '{5'h1c, 5'h1d, 5'h1e, 5'h1f, 5'h05};
  logic [7:0] rst_v [5] = '{8'h00, 8'h00, 8'h48, 8'h00, 8'h00};
  logic [7:0] wv [5] = '{8'h85, 8'h5a, 8'h77, 8'hc0, 8'hff};
  logic [7:0] rb [5] = '{8'h85, 8'h5a, 8'h76, 8'hc0, 8'h00};
  logic [7:0] ta [4] = '{8'h5a, 8'h00, 8'hff, 8'h33};
  always #25 clk_sys_i = ~clk_sys_i;
  phc_top #(.FIFO_DEPTH(8)) dut (.clk_sys_i, .reset_i, .cfg_addr_i, .cfg_wdata_i, .cfg_wr_i, .cfg_rd_i,
    .cfg_rdata_o, .cfg_o, .standby_i, .rx_valid_i, .rx_start_i, .rx_data_i, .rx_ready_o, .crc_done_i, .crc_ok_i,
    .fifo_wr_i, .fifo_wdata_i, .fifo_rd_i, .fifo_rdata_o, .fifo_rvalid_o, .fifo_empty_o, .pkt_drop_o);
  phc_host_model host (.clk_sys_i, .cfg_addr_o(cfg_addr_i), .cfg_wdata_o(cfg_wdata_i), .cfg_wr_o(cfg_wr_i),
    .cfg_rd_o(cfg_rd_i), .cfg_rdata_i(cfg_rdata_o));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  // sticky drop record and hang limit
  always @(posedge clk_sys_i) begin
    cycles++;
    if (pkt_drop_o) drop_seen <= 1'b1;
    if (cycles == 4000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rx(input logic [7:0] d, input logic s);
    @(negedge clk_sys_i);
    rx_valid_i = 1'b1;
    rx_start_i = s;
    rx_data_i = d;
  endtask : rx
  task automatic rx_idle;
    @(negedge clk_sys_i);
    rx_valid_i = 1'b0;
    rx_start_i = 1'b0;
    rx_data_i = ~rx_data_i;
    repeat (2) @(negedge clk_sys_i);
  endtask : rx_idle
  task automatic crc(input logic ok);
    @(negedge clk_sys_i);
    crc_done_i = 1'b1;
    crc_ok_i = ok;
    @(negedge clk_sys_i);
    crc_done_i = 1'b0;
    crc_ok_i = ~ok;
  endtask : crc
  task automatic pop;
    @(negedge clk_sys_i);
    fifo_rd_i = 1'b1;
    @(negedge clk_sys_i);
    fifo_rd_i = 1'b0;
  endtask : pop
  initial begin
    repeat (20) @(negedge clk_sys_i);
    reset_i = 1'b0;
    // register rows: reset value, write, readback
    for (int i = 0; i < 5; i++) begin
      host.rd(ra[i], rd_v);
      chk("reset value", rst_v[i], rd_v);
      host.wr(ra[i], wv[i]);
      host.rd(ra[i], rd_v);
      chk("readback", rb[i], rd_v);
    end
    for (int c = 0; c < 4; c++) begin
      host.wr(phc_pkg::ADDR_FORMAT, {1'b0, c[1:0], 5'h08});
      @(negedge clk_sys_i);
      chk("preamble", 8'(c + 1), 8'(cfg_o.preamble_bytes));
    end
    // address filter: every mode against node, zero, ones and a stranger
    host.wr(phc_pkg::ADDR_CODING, 8'h02);
    host.wr(phc_pkg::ADDR_NODE, 8'h5a);
    host.wr(phc_pkg::ADDR_FIFOCTL, 8'h00);
    for (int m = 0; m < 4; m++) begin
      host.wr(phc_pkg::ADDR_FORMAT, {5'h09, m[1:0], 1'b0});
      foreach (ta[k]) begin
        acc = m == 0 || ta[k] == 8'h5a || (m > 1 && ta[k] == 8'h00) || (m == 3 && ta[k] == 8'hff);
        drop_seen = 1'b0;
        rx(ta[k], 1'b1);
        rx(8'h11, 1'b0);
        rx_idle();
        chk("drop", 8'(!acc), 8'(drop_seen));
        chk("empty", 8'(!acc), 8'(fifo_empty_o));
        crc(1'b0);
        host.rd(phc_pkg::ADDR_FORMAT, rd_v);
        chk("crc status", 8'h00, 8'(rd_v[0]));
        chk("flushed", 8'h01, 8'(fifo_empty_o));
      end
    end
    // variable length: one over the limit, then exactly at it
    host.wr(phc_pkg::ADDR_FORMAT, 8'hc8);
    for (int n = 3; n > 1; n--) begin
      drop_seen = 1'b0;
      rx(8'(n), 1'b1);
      for (int j = 0; j < n; j++) rx(8'(j + 32), 1'b0);
      rx_idle();
      chk("length drop", 8'(n == 3), 8'(drop_seen));
    end
    chk("tx length", 8'h00, 8'(cfg_o.tx_length));
    // variable length with node filter: address byte follows the length byte
    host.wr(phc_pkg::ADDR_FORMAT, 8'hca);
    foreach (ta[k]) begin
      drop_seen = 1'b0;
      rx(8'h02, 1'b1);
      rx(ta[k], 1'b0);
      rx(8'h44, 1'b0);
      rx_idle();
      chk("address drop", 8'(ta[k] != 8'h5a), 8'(drop_seen));
    end
    // fill to refusal, keep on crc failure, drain in standby
    host.wr(phc_pkg::ADDR_CODING, 8'h08);
    host.wr(phc_pkg::ADDR_FORMAT, 8'h48);
    crc(1'b0);
    host.wr(phc_pkg::ADDR_FIFOCTL, 8'hc0);
    chk("flushed", 8'h01, 8'(fifo_empty_o));
    for (int i = 0; i < 8; i++) rx(8'(i + 1), i == 0);
    rx_idle();
    chk("full", 8'h00, 8'(rx_ready_o));
    crc(1'b1);
    host.rd(phc_pkg::ADDR_FORMAT, rd_v);
    chk("crc pass", 8'h49, rd_v);
    crc(1'b0);
    @(negedge clk_sys_i);
    chk("kept", 8'h00, 8'(fifo_empty_o));
    standby_i = 1'b1;
    for (int i = 0; i < 8; i++) begin
      pop();
      chk("pop data", 8'(i + 1), fifo_rdata_o);
      chk("pop valid", 8'h01, 8'(fifo_rvalid_o));
    end
    host.wr(phc_pkg::ADDR_FIFOCTL, 8'h80);
    pop();
    chk("refused read", 8'h00, 8'(fifo_rvalid_o));
    @(negedge clk_sys_i);
    fifo_wr_i = 1'b1;
    fifo_wdata_i = 8'h3c;
    @(negedge clk_sys_i);
    fifo_wr_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    chk("host write", 8'h00, 8'(fifo_empty_o));
    end_of_test();
  end
endmodule : tb_packet_handler_config
